// ===== inc/rssk_pkg.sv
`default_nettype none
package rssk_pkg;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned NIB_W      = 4;
    localparam int unsigned MSB_POS    = 7;
    localparam int unsigned LSB_POS    = 0;
    localparam logic [7:0]  ACC_RST    = 8'h00;
    localparam logic        FLAG_RST   = 1'b0;
    localparam logic [7:0]  DEC_STEP   = 8'h01;
    localparam logic [7:0]  ZERO_BYTE  = 8'h00;
    // a skipped decrement takes this many instruction cycles in all
    localparam int unsigned SKIP_CYCLES = 3;

    // operation codes on i_op
    typedef enum logic [1:0] {
        rssk_rotate_right_carry_to_acc = 2'h0,
        rssk_subtract_borrow_to_acc    = 2'h1,
        rssk_subtract_borrow_to_mem    = 2'h2,
        rssk_decrement_skip_zero       = 2'h3
    } rssk_op_e;

    // gray coded along idle -> dummy -> fetch; the step from fetch back to idle flips both bits
    typedef enum logic [1:0] {
        RSSK_IDLE  = 2'h0,
        RSSK_DUMMY = 2'h1,
        RSSK_FETCH = 2'h3
    } rssk_state_e;

    typedef struct packed {
        rssk_state_e      state;
        logic [7:0]       accumulator;
        logic             carry;
        logic             overflow_flag;
        logic             zero;
        logic             aux_carry_flag;
        logic             signed_compare_flag;
        logic             chained_zero_flag;
        logic             mem_wr;
        logic [7:0]       mem_wdata;
        logic             skip;
        logic             ready;
        logic             done;
    } rssk_regs_s;
endpackage : rssk_pkg
`default_nettype wire

// ===== core/rssk_sub8.sv
`default_nettype none
module rssk_sub8
    import rssk_pkg::*;
#(
    parameter int unsigned W = DATA_W
) (
    input  wire logic [W-1:0] i_minuend,
    input  wire logic [W-1:0] i_subtrahend,
    input  wire logic         i_carry,
    output logic      [W-1:0] o_diff,
    output logic              o_carry,
    output logic              o_aux_carry,
    output logic              o_overflow
);
    logic [W:0]       wide;
    logic [NIB_W:0]   low;
    logic             borrow_in;

    // minuend minus subtrahend minus inverted carry; carry set means no borrow
    always_comb begin
        borrow_in   = ~i_carry;
        wide        = {1'b0, i_minuend} - {1'b0, i_subtrahend} - {{W{1'b0}}, borrow_in};
        low         = {1'b0, i_minuend[NIB_W-1:0]} - {1'b0, i_subtrahend[NIB_W-1:0]}
                      - {{NIB_W{1'b0}}, borrow_in};
        o_diff      = wide[W-1:0];
        o_carry     = ~wide[W];
        o_aux_carry = ~low[NIB_W];
        o_overflow  = (i_minuend[W-1] != i_subtrahend[W-1]) && (wide[W-1] != i_minuend[W-1]);
    end
endmodule : rssk_sub8
`default_nettype wire

// ===== core/rssk_exec.sv
// Operation
// RL1 - Rotate-right-through-carry shifts the memory byte right one bit into the accumulator, old carry into bit 7, memory bit 0 into carry.
// RL2 - The rotate leaves the memory byte untouched and changes only the carry besides the accumulator.
// RL3 - Subtract-with-borrow puts accumulator minus memory minus inverted carry into the accumulator, carry 0 on negative else 1, and updates overflow, zero, aux carry and both compare flags.
// RL4 - The memory form of subtract-with-borrow computes the same result and flags but writes the memory byte instead.
// RL5 - Decrement-and-skip lowers the memory byte by one and skips the next instruction when the result is zero.
// RL6 - A skip inserts a dummy cycle while the next instruction is fetched, three instruction cycles in all.
// RL7 - A nonzero decrement result lets execution carry on with the next instruction.
// RL8 - Decrement-and-skip writes the decremented byte back to the same memory byte and touches no flag.
`default_nettype none
module rssk_exec
    import rssk_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_b,
    input  wire logic        i_op_valid,
    input  wire logic [1:0]  i_op,
    input  wire logic [7:0]  i_mem_data,
    input  wire logic        i_acc_wr,
    input  wire logic [7:0]  i_acc_wdata,
    input  wire logic        i_carry_wr,
    input  wire logic        i_carry_wdata,
    output logic             o_ready,
    output logic             o_done,
    output logic [7:0]       o_accumulator,
    output logic             o_carry,
    output logic             o_overflow_flag,
    output logic             o_zero,
    output logic             o_aux_carry_flag,
    output logic             o_signed_compare_flag,
    output logic             o_chained_zero_flag,
    output logic             o_mem_wr,
    output logic [7:0]       o_mem_wdata,
    output logic             o_skip
);
    // whole state and its next value
    rssk_regs_s  r;
    rssk_regs_s  next_r;

    // op decode
    rssk_op_e    op;
    logic        take;
    logic        is_rot;
    logic        is_sub_acc;
    logic        is_sub_mem;
    logic        is_dec;

    // rotate path
    logic [7:0]  rot_val;
    logic        rot_carry;

    // subtract path
    logic [7:0]  sub_diff;
    logic        sub_carry;
    logic        sub_aux;
    logic        sub_ovf;
    logic        sub_zero;
    logic        sub_sign_cmp;
    logic        sub_chain_zero;

    // decrement path
    logic [7:0]  dec_val;
    logic        dec_zero;

    // an op is taken only while the unit sits idle and ready
    // a request while a skip runs is dropped, not queued; the caller waits for ready
    assign op   = rssk_op_e'(i_op);
    assign take = i_op_valid && r.ready;

    // decode of the taken op, at most one of these is high
    assign is_rot     = take && (op == rssk_rotate_right_carry_to_acc);
    assign is_sub_acc = take && (op == rssk_subtract_borrow_to_acc);
    assign is_sub_mem = take && (op == rssk_subtract_borrow_to_mem);
    assign is_dec     = take && (op == rssk_decrement_skip_zero);

    // rotate right through carry, old carry in at the top, bit 0 out
    assign rot_val   = {r.carry, i_mem_data[MSB_POS:1]}; // RL1
    assign rot_carry = i_mem_data[LSB_POS];              // RL1

    // decrement and its skip test, both from the byte as read
    assign dec_val  = i_mem_data - DEC_STEP;  // RL5
    assign dec_zero = (dec_val == ZERO_BYTE); // RL5

    // shared subtractor for both subtract forms
    // it reads the registered carry, so a carry load in the same cycle is not seen
    rssk_sub8 #(
        .W (DATA_W)
    ) u_sub (
        .i_minuend    (r.accumulator),
        .i_subtrahend (i_mem_data),
        .i_carry      (r.carry),
        .o_diff       (sub_diff),
        .o_carry      (sub_carry),
        .o_aux_carry  (sub_aux),
        .o_overflow   (sub_ovf)
    );

    // flags derived from the difference
    assign sub_zero       = (sub_diff == ZERO_BYTE);         // RL3
    // set while the signed accumulator is not below subtrahend plus borrow
    assign sub_sign_cmp   = ~(sub_ovf ^ sub_diff[MSB_POS]); // RL3
    // chained zero stays set only while every byte of the chain came out zero
    assign sub_chain_zero = sub_zero && r.chained_zero_flag; // RL3

    // next state of the whole execution unit
    always_comb begin
        next_r        = r;
        // write strobe and done are single-cycle pulses
        next_r.mem_wr = 1'b0;
        next_r.done   = 1'b0;
        unique case (r.state)
            RSSK_IDLE: begin
                // seeding loads, only between ops; an op in the same cycle wins for what it writes
                if (i_acc_wr) begin
                    next_r.accumulator = i_acc_wdata;
                end
                // a carry load opens a fresh multi-byte chain
                if (i_carry_wr) begin
                    next_r.carry             = i_carry_wdata;
                    next_r.chained_zero_flag = 1'b1;
                end
                // rotate: accumulator and carry only
                if (is_rot) begin
                    next_r.accumulator = rot_val;   // RL1
                    next_r.carry       = rot_carry; // RL1
                    next_r.done        = 1'b1;
                    // no memory write and no other flag here // RL2
                end
                // subtract with borrow: result to accumulator or memory, all six flags
                if (is_sub_acc || is_sub_mem) begin
                    if (is_sub_acc) begin
                        next_r.accumulator = sub_diff; // RL3
                    end else begin
                        next_r.mem_wr    = 1'b1;       // RL4
                        next_r.mem_wdata = sub_diff;   // RL4
                    end
                    next_r.carry               = sub_carry;      // RL3
                    next_r.overflow_flag       = sub_ovf;        // RL3
                    next_r.zero                = sub_zero;       // RL3
                    next_r.aux_carry_flag      = sub_aux;        // RL3
                    next_r.signed_compare_flag = sub_sign_cmp;   // RL3
                    next_r.chained_zero_flag   = sub_chain_zero; // RL3
                    next_r.done                = 1'b1;
                end
                // decrement: write back the lowered byte, flags left alone
                if (is_dec) begin
                    next_r.mem_wr    = 1'b1;    // RL8
                    next_r.mem_wdata = dec_val; // RL5
                    if (dec_zero) begin
                        // suppress the next instruction, done comes after the dummy and fetch cycles
                        next_r.state = RSSK_DUMMY; // RL5
                        next_r.skip  = 1'b1;       // RL6
                        next_r.ready = 1'b0;       // RL6
                    end else begin
                        // nonzero: finish now and accept the next op
                        next_r.done = 1'b1; // RL7
                    end
                end
            end
            RSSK_DUMMY: begin
                // dummy cycle while the skipped instruction is fetched
                next_r.state = RSSK_FETCH; // RL6
            end
            RSSK_FETCH: begin
                // third cycle of the skip: release the unit and report done
                next_r.state = RSSK_IDLE; // RL6
                next_r.skip  = 1'b0;
                next_r.ready = 1'b1;
                next_r.done  = 1'b1;
            end
            default: begin
                // unused state code: recover to idle without a done pulse
                next_r.state = RSSK_IDLE;
                next_r.skip  = 1'b0;
                next_r.ready = 1'b1;
            end
        endcase
    end

    // single register of the whole state
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            // idle, nothing in progress
            r.state               <= RSSK_IDLE;
            // accumulator and every status flag clear
            r.accumulator         <= ACC_RST;
            r.carry               <= FLAG_RST;
            r.overflow_flag       <= FLAG_RST;
            r.zero                <= FLAG_RST;
            r.aux_carry_flag      <= FLAG_RST;
            r.signed_compare_flag <= FLAG_RST;
            r.chained_zero_flag   <= FLAG_RST;
            // no memory write pending
            r.mem_wr              <= 1'b0;
            r.mem_wdata           <= ZERO_BYTE;
            // no skip, ready for the first op
            r.skip                <= 1'b0;
            r.ready               <= 1'b1;
            r.done                <= 1'b0;
        end else begin
            // everything else comes from the next-state copy
            r <= next_r;
        end
    end

    // outputs straight from the state register
    assign o_ready               = r.ready;
    assign o_done                = r.done;

    // accumulator and status flags
    assign o_accumulator         = r.accumulator;
    assign o_carry               = r.carry;
    assign o_overflow_flag       = r.overflow_flag;
    assign o_zero                = r.zero;
    assign o_aux_carry_flag      = r.aux_carry_flag;
    assign o_signed_compare_flag = r.signed_compare_flag;
    assign o_chained_zero_flag   = r.chained_zero_flag;

    // memory write port and skip marker
    assign o_mem_wr              = r.mem_wr;
    assign o_mem_wdata           = r.mem_wdata;
    assign o_skip                = r.skip;
endmodule : rssk_exec
`default_nettype wire

// ===== test/rssk_exec_checker.sv
`default_nettype none
module rssk_exec_checker
    import rssk_pkg::*;
(
    input wire logic       i_clk_sys,
    input wire logic       i_rst_b,
    input wire logic       i_op_valid,
    input wire logic [1:0] i_op,
    input wire logic [7:0] i_mem_data,
    input wire logic       i_acc_wr,
    input wire logic       i_carry_wr,
    input wire logic       o_ready,
    input wire logic       o_done,
    input wire logic [7:0] o_accumulator,
    input wire logic       o_carry,
    input wire logic       o_zero,
    input wire logic       o_mem_wr,
    input wire logic [7:0] o_mem_wdata,
    input wire logic       o_skip
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    // an op is taken only while ready
    logic take;
    assign take = i_op_valid && o_ready;
    sequence dec_to_zero; take && i_op == 2'h3 && i_mem_data == 8'h01; endsequence
    sequence skip_tail; (o_skip && !o_ready)[*2] ##1 (o_done && o_ready && !o_skip); endsequence
    chk_rot_result: assert property (
        take && i_op == 2'h0 |=> o_accumulator == {$past(o_carry), $past(i_mem_data[7:1])}
        && o_carry == $past(i_mem_data[0])) else $error("rotate result wrong");
    chk_rot_no_write: assert property (take && i_op == 2'h0 |=> !o_mem_wr)
        else $error("rotate wrote memory");
    chk_sub_carry: assert property (
        take && i_op == 2'h1 |=> o_carry == ({1'b0, $past(o_accumulator)}
        >= {1'b0, $past(i_mem_data)} + {8'h00, !$past(o_carry)})) else $error("borrow carry wrong");
    chk_subm_acc_kept: assert property (
        take && i_op == 2'h2 && !i_acc_wr |=> o_mem_wr && $stable(o_accumulator))
        else $error("memory subtract path wrong");
    chk_dec_wdata: assert property (
        take && i_op == 2'h3 |=> o_mem_wr && o_mem_wdata == $past(i_mem_data) - 8'h01)
        else $error("decrement write wrong");
    chk_dec_flags: assert property (
        take && i_op == 2'h3 && !i_carry_wr |=> $stable(o_carry) && $stable(o_zero))
        else $error("decrement touched a flag");
    chk_busy_refused: assert property (
        !o_ready |=> !o_mem_wr && $stable(o_accumulator)) else $error("request taken during skip");
    chk_skip_seq: assert property (dec_to_zero |=> skip_tail)
        else $error("skip sequence wrong");
    chk_dec_no_skip: assert property (
        take && i_op == 2'h3 && i_mem_data != 8'h01 |=> o_done && !o_skip) else $error("unexpected skip");
endmodule : rssk_exec_checker
bind rssk_exec rssk_exec_checker i_chk (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_op_valid(i_op_valid),
    .i_op(i_op), .i_mem_data(i_mem_data), .i_acc_wr(i_acc_wr), .i_carry_wr(i_carry_wr),
    .o_ready(o_ready), .o_done(o_done), .o_accumulator(o_accumulator),
    .o_carry(o_carry), .o_zero(o_zero), .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata), .o_skip(o_skip));
`default_nettype wire

// ===== test/rotate_subtract_skip_ops_tb_top.sv
`default_nettype none
module rotate_subtract_skip_ops_tb_top
    import rssk_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_b = 1'b0, vld = 1'b0, awr = 1'b0, cwr = 1'b0, cwd = 1'b0;
    logic [1:0] op = 2'h0;
    logic [7:0] mem = 8'h00, awd = 8'h00, acc, wdat;
    logic rdy, done, c, ov, z, ac, sc, cz, mwr, skip;
    int error_cnt = 0, checks = 0, cyc = 0;
    rssk_exec i_dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_op_valid(vld), .i_op(op), .i_mem_data(mem),
        .i_acc_wr(awr), .i_acc_wdata(awd), .i_carry_wr(cwr), .i_carry_wdata(cwd), .o_ready(rdy), .o_done(done),
        .o_accumulator(acc), .o_carry(c), .o_overflow_flag(ov), .o_zero(z), .o_aux_carry_flag(ac),
        .o_signed_compare_flag(sc), .o_chained_zero_flag(cz), .o_mem_wr(mwr), .o_mem_wdata(wdat), .o_skip(skip));
    // clock and hang guard
    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin error_cnt++; $display("wrong value %s expected %h seen %h", n, e, g); end
    endtask : chk_byte
    task automatic chk_bit(input string n, input logic e, input logic g);
        checks++;
        if (g !== e) begin error_cnt++; $display("wrong value %s expected %b seen %b", n, e, g); end
    endtask : chk_bit
    task automatic seed(input logic [7:0] a, input logic cin);
        @(negedge clk) {awr, awd, cwr, cwd} = {1'b1, a, 1'b1, cin};
        @(negedge clk) {awr, cwr} = 2'b00;
    endtask : seed
    // one op taken at the next rising edge, returns where results have settled
    task automatic issue(input logic [1:0] o, input logic [7:0] m);
        @(negedge clk) {vld, op, mem} = {1'b1, o, m};
        @(negedge clk) vld = 1'b0;
    endtask : issue
    task automatic t_rotate();
        seed(8'h00, 1'b1);
        issue(2'h0, 8'hA5);
        chk_byte("acc", 8'hD2, acc);
        chk_bit("carry", 1'b1, c);
        chk_bit("mem_wr", 1'b0, mwr);
        issue(2'h0, 8'h4A);
        chk_byte("acc", 8'hA5, acc);
        chk_bit("carry", 1'b0, c);
    endtask : t_rotate
    task automatic t_sub();
        logic [7:0] av[5] = '{8'h50, 8'h30, 8'h00, 8'h10, 8'h80};
        logic [7:0] mv[5] = '{8'h30, 8'h50, 8'h00, 8'h0F, 8'h01};
        logic       cv[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
        logic [8:0] d;
        int         sd;
        for (int i = 0; i < 10; i++) begin
            d  = {1'b0, av[i%5]} - {1'b0, mv[i%5]} - {8'h00, !cv[i%5]};
            sd = int'(signed'(av[i%5])) - int'(signed'(mv[i%5])) - int'(!cv[i%5]);
            seed(av[i%5], cv[i%5]);
            issue((i < 5) ? 2'h1 : 2'h2, mv[i%5]);
            chk_byte("result", d[7:0], (i < 5) ? acc : wdat);
            chk_bit("carry", ~d[8], c);
            chk_bit("zero", d[7:0] == 8'h00, z);
            chk_bit("overflow", (sd > 127) || (sd < -128), ov);
            chk_bit("aux carry", int'(av[i%5][3:0]) >= int'(mv[i%5][3:0]) + int'(!cv[i%5]), ac);
            chk_bit("signed compare", sd >= 0, sc);
            chk_bit("chained zero", d[7:0] == 8'h00, cz);
            if (i >= 5) begin
                chk_byte("acc kept", av[i%5], acc);
                chk_bit("mem_wr", 1'b1, mwr);
            end
        end
        // a chain without a fresh carry load stays zero only while every byte was zero
        seed(8'h05, 1'b1);
        issue(2'h1, 8'h05);
        issue(2'h1, 8'h00);
        chk_bit("chained zero", 1'b1, cz);
        issue(2'h1, 8'hFF);
        issue(2'h1, 8'h00);
        chk_bit("zero", 1'b1, z);
        chk_bit("chained zero", 1'b0, cz);
    endtask : t_sub
    task automatic t_dec();
        seed(8'h00, 1'b1);
        issue(2'h3, 8'h05);
        chk_byte("wdata", 8'h04, wdat);
        chk_bit("done", 1'b1, done);
        chk_bit("carry", 1'b1, c);
        issue(2'h3, 8'h00);
        chk_bit("skip", 1'b0, skip);
        issue(2'h3, 8'h01);
        chk_bit("skip", 1'b1, skip);
        chk_bit("mem_wr", 1'b1, mwr);
        chk_bit("ready", 1'b0, rdy);
        @(negedge clk) begin
            chk_bit("skip", 1'b1, skip);
            {vld, op, mem} = {1'b1, 2'h0, 8'hFF}; // refused while the skip runs
        end
        @(negedge clk) begin
            vld = 1'b0;
            chk_bit("done", 1'b1, done);
            chk_bit("skip", 1'b0, skip);
            chk_bit("ready", 1'b1, rdy);
            chk_byte("acc", 8'h00, acc);
        end
    endtask : t_dec
    task automatic tally_and_finish();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        chk_bit("ready", 1'b1, rdy);
        t_rotate();
        t_sub();
        t_dec();
        tally_and_finish();
    end
endmodule : rotate_subtract_skip_ops_tb_top
`default_nettype wire
